// >>> rtl/pfrp_top.sv
// program-flash range protection: config register, decode, request check
// Contract
// - lower disable clear enables window at base
// - lower size writable only while disabled
// - lower size codes 1K to 8K upward
// - higher size codes 2K to 16K downward
// - open one: enabled windows protected
// - open zero: only enabled windows unprotected
// - config loaded from non-volatile word at reset
// - mode input governs register write rules
`timescale 1ns/1ps
module pfrp_top
  import pfrp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  // operating mode: 1 selects special mode
  input wire logic special_mode,
  // non-volatile word read path
  output logic [17:0] nvm_addr,
  output logic nvm_rd,
  input wire logic [7:0] nvm_data,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // program or erase requests
  input wire pfrp_req_s req,
  output logic req_accept,
  output logic req_violation,
  output logic [17:0] req_addr_out,
  output logic load_done
);

  pfrp_state_e state_q, state_d; // reset-load sequencer
  logic [7:0] cfg_q, cfg_d; // live protection configuration
  logic [7:0] rdata_q, rdata_d; // read data, one cycle after strobe
  logic viol_q, viol_d; // sticky violation status
  logic acc_q, acc_d; // accept pulse
  logic rej_q, rej_d; // reject pulse
  logic [17:0] raddr_q, raddr_d; // address of the last request
  pfrp_cfg_s cfg; // field view of cfg_q
  logic [17:0] low_end, high_start; // decoded window bounds
  logic in_low, in_high, protected_hit; // decode of request address
  logic [7:0] wmask; // which bits a write may change

  assign cfg = pfrp_cfg_s'({cfg_q[PFRP_POS_OPEN], cfg_q[PFRP_POS_HDIS],
    cfg_q[PFRP_POS_HSZ +: 2], cfg_q[PFRP_POS_LDIS], cfg_q[PFRP_POS_LSZ +: 2]});

  // window bounds from the size codes
  always_comb begin
    // lower window grows upward by powers of two from 1K
    low_end = PFRP_LOW_BASE + ((PFRP_LOW_1K << cfg.lsz) | PFRP_LOW_1K);
    // higher window grows downward from the top, 2K to 16K
    high_start = PFRP_HIGH_2K << cfg.hsz;
  end

  // address decode against both windows
  always_comb begin
    in_low = !cfg.ldis && (req.addr >= PFRP_LOW_BASE) &&
      (req.addr <= low_end);
    in_high = !cfg.hdis && (req.addr >= high_start);
    if (cfg.open_sel) begin
      // enabled windows are the protected ones
      protected_hit = in_low || in_high;
    end else begin
      // enabled windows are the only open space; all disabled means all shut
      protected_hit = !(in_low || in_high);
    end
  end

  // write mask: size fields frozen while their window is enabled
  always_comb begin
    wmask = 8'hFF;
    wmask[6] = 1'b0;
    if (!cfg.ldis) begin
      wmask[PFRP_POS_LSZ +: 2] = 2'h0;
    end
    if (!cfg.hdis) begin
      wmask[PFRP_POS_HSZ +: 2] = 2'h0;
    end
    // normal mode: open and disable bits may only move one way, so clears of open and sets of
    // disable bits are blocked; special mode leaves open and disable bits writable
    if (!special_mode) begin
      wmask[PFRP_POS_OPEN] = !cfg.open_sel;
      wmask[PFRP_POS_HDIS] = cfg.hdis ? 1'b1 : 1'b0;
      wmask[PFRP_POS_LDIS] = cfg.ldis ? 1'b1 : 1'b0;
    end
  end

  // sequencer, register file and request check, next values
  always_comb begin
    state_d = state_q;
    cfg_d = cfg_q;
    rdata_d = 8'h00;
    viol_d = viol_q;
    acc_d = 1'b0;
    rej_d = 1'b0;
    raddr_d = raddr_q;
    unique case (state_q)
      // read strobe to the non-volatile word
      PFRP_ST_FETCH: begin
        state_d = PFRP_ST_WAIT;
      end
      // data arrive one cycle after the strobe
      PFRP_ST_WAIT: begin
        cfg_d = nvm_data;
        cfg_d[6] = 1'b1;
        state_d = PFRP_ST_RUN;
      end
      // normal operation
      PFRP_ST_RUN: begin
        if (reg_wr) begin
          if (reg_addr == PFRP_OFS_CONFIG) begin
            // masked write keeps frozen bits
            cfg_d = (cfg_q & ~wmask) | (reg_wdata & wmask);
          end else if (reg_addr == PFRP_OFS_STATUS) begin
            // write one clears violation; a new hit below still wins
            if (reg_wdata[0]) begin
              viol_d = 1'b0;
            end
          end
        end
        if (req.valid) begin
          raddr_d = req.addr;
          if (protected_hit) begin
            rej_d = 1'b1;
            viol_d = 1'b1;
          end else begin
            acc_d = 1'b1;
          end
        end
      end
    endcase
    // read mux; unmapped reads return zero
    if (reg_rd) begin
      if (reg_addr == PFRP_OFS_CONFIG) begin
        rdata_d = cfg_q;
      end else if (reg_addr == PFRP_OFS_STATUS) begin
        rdata_d = {5'h00, special_mode, state_q == PFRP_ST_RUN, viol_q};
      end
    end
  end

  // registers; reset restarts the load from the non-volatile word
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= PFRP_ST_FETCH;
      cfg_q <= PFRP_CONFIG_RST;
      rdata_q <= 8'h00;
      viol_q <= 1'b0;
      acc_q <= 1'b0;
      rej_q <= 1'b0;
      raddr_q <= 18'h00000;
    end else begin
      state_q <= state_d;
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
      viol_q <= viol_d;
      acc_q <= acc_d;
      rej_q <= rej_d;
      raddr_q <= raddr_d;
    end
  end

  assign nvm_addr = PFRP_NVM_WORD;
  assign nvm_rd = (state_q == PFRP_ST_FETCH);
  assign reg_rdata = rdata_q;
  assign req_accept = acc_q;
  assign req_violation = rej_q;
  assign req_addr_out = raddr_q;
  assign load_done = (state_q == PFRP_ST_RUN);

endmodule // pfrp_top

// >>> rtl/pfrp_pkg.sv
// package for the program-flash range protection block
package pfrp_pkg;
  // register map, byte addresses on the plain register port
  localparam logic [3:0] PFRP_OFS_CONFIG = 4'h0;
  localparam logic [3:0] PFRP_OFS_STATUS = 4'h4;
  localparam logic [3:0] PFRP_OFS_LOAD = 4'h8;
  // field positions in the protection configuration
  localparam int PFRP_POS_OPEN = 7;
  localparam int PFRP_POS_HDIS = 5;
  localparam int PFRP_POS_HSZ = 3;
  localparam int PFRP_POS_LDIS = 2;
  localparam int PFRP_POS_LSZ = 0;
  // configuration value from reset until the non-volatile word is loaded
  localparam logic [7:0] PFRP_CONFIG_RST = 8'hFF;
  // global flash addresses, 18 bits wide
  localparam logic [17:0] PFRP_LOW_BASE = 18'h38000;
  localparam logic [17:0] PFRP_HIGH_TOP = 18'h3FFFF;
  localparam logic [17:0] PFRP_NVM_WORD = 18'h3FF0C;
  localparam logic [17:0] PFRP_LOW_1K = 18'h003FF;
  localparam logic [17:0] PFRP_HIGH_2K = 18'h3F800;
  // reset-load sequence length in cycles
  localparam logic [1:0] PFRP_LOAD_CYCLES = 2'h2;

  // decoded view of the configuration
  typedef struct packed {
    logic open_sel;
    logic hdis;
    logic [1:0] hsz;
    logic ldis;
    logic [1:0] lsz;
  } pfrp_cfg_s;

  // one program or erase request, valid and address
  typedef struct packed {
    logic valid;
    logic [17:0] addr;
  } pfrp_req_s;

  // reset sequence states
  typedef enum logic [2:0] {
    PFRP_ST_FETCH = 3'b001,
    PFRP_ST_WAIT = 3'b010,
    PFRP_ST_RUN = 3'b100
  } pfrp_state_e;
endpackage

// >>> bench/pfrp_checker.sv
// assertions on the ports of the range protection block
`timescale 1ns/1ps
module pfrp_checker
  import pfrp_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic special_mode,
  input wire logic [17:0] nvm_addr,
  input wire logic nvm_rd,
  input wire logic load_done,
  input wire logic [3:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire pfrp_req_s req,
  input wire logic req_accept,
  input wire logic req_violation,
  input wire logic [17:0] req_addr_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // a taken request gets exactly one answer
  a_req_one_answer: assert property (req.valid && load_done |=>
    req_accept ^ req_violation) else $error("request answer wrong");
  a_no_spurious: assert property (!(req.valid && load_done) |=>
    !req_accept && !req_violation) else $error("answer without request");
  a_addr_echo: assert property (req.valid && load_done |=>
    req_addr_out == $past(req.addr)) else $error("address not echoed");
  a_word_addr: assert property (nvm_addr == PFRP_NVM_WORD)
    else $error("wrong protection word address");
  a_fetch_first: assert property (nvm_rd |-> !load_done)
    else $error("done while fetching");
  a_done_holds: assert property (load_done |=> load_done)
    else $error("load done dropped");
  // read data only stands in the cycle after the strobe
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_mode_status: assert property (reg_rd && reg_addr == PFRP_OFS_STATUS
    |=> reg_rdata[2:1] == {$past(special_mode), $past(load_done)})
    else $error("status mode or done wrong");
  a_viol_sticky: assert property (req_violation && reg_rd &&
    reg_addr == PFRP_OFS_STATUS |=> reg_rdata[0]) else $error("no flag");
  c_accept: cover property (req_accept);
  c_violation: cover property (req_violation);
  c_special: cover property (special_mode && reg_rd);
endmodule // pfrp_checker
bind pfrp_top pfrp_checker u_chk (.clk, .srst, .special_mode, .nvm_addr,
  .nvm_rd, .load_done, .reg_addr, .reg_rd, .reg_rdata, .req, .req_accept,
  .req_violation, .req_addr_out);

// >>> bench/pfrp_top_bench.sv
// self-checking bench for the range protection block
`timescale 1ns/1ps
module pfrp_top_bench;
  import pfrp_pkg::*;
  logic clk = 0, srst = 1, special_mode = 0, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, nvm_data = 8'h84, reg_rdata;
  pfrp_req_s req = '0;
  logic nvm_rd, req_accept, req_violation, load_done;
  logic [17:0] nvm_addr, req_addr_out;
  int n_errors = 0, samples_checked = 0;
  pfrp_top uut (.clk, .srst, .special_mode, .nvm_addr, .nvm_rd, .nvm_data,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req, .req_accept,
    .req_violation, .req_addr_out, .load_done);
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [7:0] d);
    @(posedge clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data is looked at only in the cycle after the strobe
  task automatic rd(logic [3:0] a, logic [7:0] e);
    @(posedge clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
  endtask
  // v: 1 when the address should be refused
  task automatic rq(logic [17:0] a, logic v);
    @(posedge clk);
    req <= '{1'b1, a};
    @(posedge clk);
    req.valid <= 1'b0;
    #1 chk("answer", {6'h00, v, !v}, {6'h00, req_violation, req_accept});
  endtask
  task automatic t_load;
    chk("load_done", 8'h01, {7'h00, load_done});
    rd(PFRP_OFS_CONFIG, 8'hC4);
    rq(18'h3F800, 1'b1);
    rq(18'h3F7FF, 1'b0);
    rq(18'h38000, 1'b0);
    $display("test load done");
  endtask
  // normal mode: sizes frozen while enabled, open may not clear
  task automatic t_normal;
    wr(PFRP_OFS_CONFIG, 8'h87);
    wr(PFRP_OFS_CONFIG, 8'h9F);
    rd(PFRP_OFS_CONFIG, 8'hC7);
    wr(PFRP_OFS_CONFIG, 8'h03);
    rd(PFRP_OFS_CONFIG, 8'hC3);
    rq(18'h39FFF, 1'b1);
    rq(18'h3A000, 1'b0);
    $display("test normal done");
  endtask
  task automatic t_special;
    special_mode <= 1'b1;
    wr(PFRP_OFS_CONFIG, 8'h24);
    rd(PFRP_OFS_CONFIG, 8'h67);
    rq(18'h38000, 1'b1);
    wr(PFRP_OFS_CONFIG, 8'h3C);
    wr(PFRP_OFS_CONFIG, 8'h18);
    rd(PFRP_OFS_CONFIG, 8'h58);
    rq(18'h3C000, 1'b0);
    rq(18'h3BFFF, 1'b1);
    rq(18'h383FF, 1'b0);
    rq(18'h38400, 1'b1);
    $display("test special done");
  endtask
  task automatic t_status;
    rd(PFRP_OFS_STATUS, 8'h07);
    wr(PFRP_OFS_STATUS, 8'h01);
    rd(PFRP_OFS_STATUS, 8'h06);
    rd(4'hC, 8'h00);
    $display("test status done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog: the tests need well under a thousand cycles
  initial begin
    #20000;
    n_errors++;
    final_report();
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 t_load();
    t_normal();
    t_special();
    t_status();
    final_report();
  end
endmodule // pfrp_top_bench
